/* verilog/isp_pkg.sv */
package isp_pkg;
   // -------------------------------------------------
   // Timing
   // -------------------------------------------------
   localparam int CLK_MHZ                 = 125;
   localparam int T_FLASH_US              = 4500;
   localparam int T_FUSE_US               = 4500;
   localparam int T_EEPROM_US             = 9000;
   localparam int T_ERASE_US              = 9000;
   localparam int FLASH_PAGE_WRITE_DELAY  = T_FLASH_US * CLK_MHZ;
   localparam int CONFIG_BITS_WRITE_DELAY = T_FUSE_US * CLK_MHZ;
   localparam int EEPROM_WRITE_DELAY      = T_EEPROM_US * CLK_MHZ;
   localparam int CHIP_ERASE_DELAY        = T_ERASE_US * CLK_MHZ;

   // -------------------------------------------------
   // Instruction codes
   // -------------------------------------------------
   localparam logic [7:0] OP_PROG     = 8'hAC;
   localparam logic [7:0] PE_SECOND   = 8'h53;
   localparam logic [2:0] SUB_ERASE   = 3'b100;
   localparam logic [2:0] SUB_LOCK    = 3'b111;
   localparam logic [7:0] SUB_FUSE_LO = 8'hA0;
   localparam logic [7:0] SUB_FUSE_HI = 8'hA8;
   localparam logic [7:0] SUB_FUSE_EX = 8'hA4;
   localparam logic [3:0] OP_FL_RD    = 4'h2;
   localparam logic [3:0] OP_FL_LD    = 4'h4;
   localparam logic [7:0] OP_FL_WR    = 8'h4C;
   localparam logic [7:0] OP_EE_RD    = 8'hA0;
   localparam logic [7:0] OP_EE_WR    = 8'hC0;
   localparam logic [7:0] OP_EE_LD    = 8'hC1;
   localparam logic [7:0] OP_EE_PG    = 8'hC2;
   localparam logic [7:0] OP_RD_LOCK  = 8'h58;
   localparam logic [7:0] OP_RD_FUSE  = 8'h50;
   localparam logic [7:0] OP_RD_SIG   = 8'h30;
   localparam logic [7:0] OP_RD_CAL   = 8'h38;
   localparam logic [7:0] OP_POLL     = 8'hF0;
   localparam logic [7:0] SEL_ALT     = 8'h08;

   // -------------------------------------------------
   // Registers and reset values
   // -------------------------------------------------
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_STATUS  = 8'h04;
   localparam logic [7:0]  REG_CONFIG  = 8'h08;
   localparam int          CTRL_BLOCK  = 0;
   localparam logic [5:0]  LOCK_RST    = 6'h3F;
   localparam logic [7:0]  FUSE_RST    = 8'hFF;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;
   localparam logic [7:0]  ERASED_BYTE = 8'hFF;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_ARMED   = 3'b010,
      ST_ENABLED = 3'b100
   } isp_state_e;

   typedef struct packed {
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] b3;
   } isp_cmd_s;
endpackage : isp_pkg

/* verilog/isp_port.sv */
// What this block and the programmer do
// [RULE_01] Sample MOSI on serial clock rising edge
// [RULE_02] Change MISO on serial clock falling edge
// [RULE_03] Programmer holds reset, clock low at power-up
// [RULE_04] Programmer waits 20 ms, sends enable; the model waits 2000 ns
// [RULE_05] Echo 0x53 during third enable byte
// [RULE_06] Programmer sends all four bytes, retries
// [RULE_07] Enable accepted only while reset low
// [RULE_08] Page load: 6-bit word index, byte select
// [RULE_09] Programmer loads low byte before high
// [RULE_10] Page write commits buffer to addressed page
// [RULE_11] Programmer waits 4.5 ms without polling; the testbench polls until busy clears
// [RULE_12] EEPROM byte write self-erases; 9 ms wait
// [RULE_13] EEPROM buffer load at 2-bit position
// [RULE_14] EEPROM page write changes loaded bytes only
// [RULE_15] Chip erase clears flash and EEPROM
// [RULE_16] Read returns addressed content in byte four
// [RULE_17] EEPROM read address from bytes two, three
// [RULE_18] Read and program lock bits, zero programmed
// [RULE_19] Write low, high, extended config bits
// [RULE_20] Read config bits in byte four
// [RULE_21] Poll returns busy in last bit
// [RULE_22] Programmer releases reset at session end
// [RULE_23] Programmer keeps clock phases long enough
// [RULE_24] Erase sets every location to 0xFF
// [RULE_25] MSB first, four bytes per instruction
`timescale 1ns/1ps
module isp_port
   import isp_pkg::*;
#(
   parameter int         FA_W       = 13,
   parameter int         PG_W       = 6,
   parameter int         EA_W       = 9,
   parameter int         FLASH_WAIT = FLASH_PAGE_WRITE_DELAY,
   parameter int         FUSE_WAIT  = CONFIG_BITS_WRITE_DELAY,
   parameter int         EE_WAIT    = EEPROM_WRITE_DELAY,
   parameter int         ERASE_WAIT = CHIP_ERASE_DELAY,
   // Arbitrary signature and calibration values
   parameter logic [7:0] SIG0       = 8'h01,
   parameter logic [7:0] SIG1       = 8'h02,
   parameter logic [7:0] SIG2       = 8'h03,
   parameter logic [7:0] CAL        = 8'h80
) (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        pin_rst_n,
   input  wire logic        sck,
   input  wire logic        mosi,
   output logic             miso,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);

   // -------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------
   logic [2:0] sck_q;
   logic [1:0] mosi_q;
   logic [1:0] prst_q;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sck_q  <= 3'b000;
         mosi_q <= 2'b00;
         prst_q <= 2'b11;
      end else begin
         sck_q  <= {sck_q[1:0], sck};
         mosi_q <= {mosi_q[0], mosi};
         prst_q <= {prst_q[0], pin_rst_n};
      end
   end

   wire sck_rise  = sck_q[1] & ~sck_q[2];
   wire sck_fall  = ~sck_q[1] & sck_q[2];
   wire prog_mode = ~prst_q[1];

   // -------------------------------------------------
   // Frame shifter
   // -------------------------------------------------
   isp_state_e state;
   isp_state_e next_state;
   isp_cmd_s   cmd;
   logic [4:0] cnt;
   logic [7:0] sh;
   logic [7:0] out_sr;
   logic [7:0] rd;
   logic       blocked;
   logic [31:0] wait_cnt;

   wire [7:0] in_byte   = {sh[6:0], mosi_q[1]};
   wire       byte_end  = sck_rise && cnt[2:0] == 3'd7;
   wire       frame_end = sck_rise && cnt == 5'd31;
   wire       busy      = wait_cnt != 32'h0000_0000;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt <= 5'd0;
         sh  <= 8'h00;
         cmd <= '0;
      end else if (state == ST_IDLE) begin
         cnt <= 5'd0;
      end else if (sck_rise) begin
         cnt <= cnt + 5'd1;   // [RULE_25]
         sh  <= in_byte;      // [RULE_01]
         if (byte_end) begin
            unique case (cnt[4:3])
               2'd0:    cmd.b1 <= in_byte;
               2'd1:    cmd.b2 <= in_byte;
               2'd2:    cmd.b3 <= in_byte;
               default: ;
            endcase
         end
      end
   end

   // Each byte echoes the previous one; byte four carries read data
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         out_sr <= 8'h00;
         miso   <= 1'b0;
      end else if (state == ST_IDLE) begin
         out_sr <= 8'h00;
      end else if (byte_end) begin
         out_sr <= (cnt[4:3] == 2'd2) ? rd : in_byte;   // [RULE_05]
      end else if (sck_fall) begin
         miso   <= out_sr[7];                            // [RULE_02]
         out_sr <= {out_sr[6:0], 1'b0};
      end
   end

   // -------------------------------------------------
   // Mode control
   // -------------------------------------------------
   wire pe_ok = cmd.b1 == OP_PROG && cmd.b2 == PE_SECOND;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE:    next_state = ST_ARMED;
         ST_ARMED:   if (frame_end && pe_ok) next_state = ST_ENABLED;
         ST_ENABLED: next_state = ST_ENABLED;
      endcase
      if (!prog_mode)
         next_state = ST_IDLE;                           // [RULE_07]
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // -------------------------------------------------
   // Instruction decode
   // -------------------------------------------------
   // A busy part ignores writes so an early access cannot corrupt one
   wire go      = frame_end && state == ST_ENABLED && !blocked && !busy;
   wire is_prog = cmd.b1 == OP_PROG;
   wire do_erase = go && is_prog && cmd.b2[7:5] == SUB_ERASE;
   wire do_lock  = go && is_prog && cmd.b2[7:5] == SUB_LOCK;
   wire do_flo   = go && is_prog && cmd.b2 == SUB_FUSE_LO;
   wire do_fhi   = go && is_prog && cmd.b2 == SUB_FUSE_HI;
   wire do_fex   = go && is_prog && cmd.b2 == SUB_FUSE_EX;
   wire do_pload = go && cmd.b1[7:4] == OP_FL_LD && cmd.b1[2:0] == 3'b000;
   wire do_pwr   = go && cmd.b1 == OP_FL_WR;
   wire do_ewr   = go && cmd.b1 == OP_EE_WR;
   wire do_eload = go && cmd.b1 == OP_EE_LD;
   wire do_epage = go && cmd.b1 == OP_EE_PG;

   wire [12:0] fl_word = {cmd.b2[4:0], cmd.b3};
   wire [FA_W-1:0] fa_rd = FA_W'({cmd.b2[4:0], in_byte});
   wire [FA_W-PG_W-1:0] fw_page = (FA_W-PG_W)'(fl_word >> PG_W);
   wire [EA_W-1:0] ea_rd = EA_W'({cmd.b2[1:0], in_byte});
   wire [EA_W-1:0] ea_wr = EA_W'({cmd.b2[1:0], cmd.b3});
   wire [EA_W-3:0] ee_page = (EA_W-2)'({cmd.b2[1:0], cmd.b3[7:2]});

   // -------------------------------------------------
   // Configuration bits and busy timer
   // -------------------------------------------------
   logic [5:0] lock;
   logic [7:0] fuse_lo;
   logic [7:0] fuse_hi;
   logic [7:0] fuse_ex;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lock    <= LOCK_RST;
         fuse_lo <= FUSE_RST;
         fuse_hi <= FUSE_RST;
         fuse_ex <= FUSE_RST;
      end else begin
         if (do_erase)
            lock <= LOCK_RST;
         else if (do_lock)
            lock <= lock & in_byte[5:0];   // [RULE_18]
         if (do_flo)
            fuse_lo <= in_byte;            // [RULE_19]
         if (do_fhi)
            fuse_hi <= in_byte;            // [RULE_19]
         if (do_fex)
            fuse_ex <= in_byte;            // [RULE_19]
      end
   end

   wire fuse_go = do_lock | do_flo | do_fhi | do_fex;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         wait_cnt <= 32'h0000_0000;
      else if (do_erase)
         wait_cnt <= 32'(ERASE_WAIT);
      else if (do_pwr)
         wait_cnt <= 32'(FLASH_WAIT);     // [RULE_11]
      else if (fuse_go)
         wait_cnt <= 32'(FUSE_WAIT);
      else if (do_ewr | do_epage)
         wait_cnt <= 32'(EE_WAIT);        // [RULE_12]
      else if (busy)
         wait_cnt <= wait_cnt - 32'h0000_0001;
   end

   // -------------------------------------------------
   // Flash and page buffer
   // -------------------------------------------------
   logic [15:0] flash [2**FA_W];
   logic [15:0] pbuf  [2**PG_W];

   genvar gi;
   generate
      for (gi = 0; gi < 2**PG_W; gi++) begin : g_pbuf
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn)
               pbuf[gi] <= ERASED_WORD;
            else if (do_pload && cmd.b3[PG_W-1:0] == PG_W'(gi)) begin
               if (cmd.b1[3])
                  pbuf[gi][15:8] <= in_byte;   // [RULE_08]
               else
                  pbuf[gi][7:0] <= in_byte;    // [RULE_08]
            end
         end
      end
      for (gi = 0; gi < 2**FA_W; gi++) begin : g_flash
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn)
               flash[gi] <= ERASED_WORD;
            else if (do_erase)
               flash[gi] <= ERASED_WORD;               // [RULE_24]
            else if (do_pwr
                     && fw_page == (FA_W-PG_W)'(gi >> PG_W))
               flash[gi] <= pbuf[PG_W'(gi)];           // [RULE_10]
         end
      end
   endgenerate

   // -------------------------------------------------
   // EEPROM and page buffer
   // -------------------------------------------------
   logic [7:0] ee   [2**EA_W];
   logic [7:0] ebuf [4];
   logic [3:0] emask;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         emask <= 4'h0;
         for (int i = 0; i < 4; i++)
            ebuf[i] <= ERASED_BYTE;
      end else if (do_epage) begin
         emask <= 4'h0;
      end else if (do_eload) begin
         ebuf[cmd.b3[1:0]]  <= in_byte;   // [RULE_13]
         emask[cmd.b3[1:0]] <= 1'b1;
      end
   end

   generate
      for (gi = 0; gi < 2**EA_W; gi++) begin : g_ee
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn)
               ee[gi] <= ERASED_BYTE;
            else if (do_erase)
               ee[gi] <= ERASED_BYTE;                  // [RULE_15]
            // Erase before write is implied by storing the byte whole
            else if (do_ewr && ea_wr == EA_W'(gi))
               ee[gi] <= in_byte;                      // [RULE_12]
            else if (do_epage && emask[gi % 4]
                     && ee_page == (EA_W-2)'(gi >> 2))
               ee[gi] <= ebuf[gi % 4];                 // [RULE_14]
         end
      end
   endgenerate

   // -------------------------------------------------
   // Read data for byte four
   // -------------------------------------------------
   wire alt = cmd.b2 == SEL_ALT;
   wire nul = cmd.b2 == 8'h00;

   always_comb begin
      rd = 8'h00;
      if (cmd.b1[7:4] == OP_FL_RD && cmd.b1[2:0] == 3'b000)
         rd = cmd.b1[3] ? flash[fa_rd][15:8]
                        : flash[fa_rd][7:0];           // [RULE_16]
      else if (cmd.b1 == OP_EE_RD)
         rd = ee[ea_rd];                               // [RULE_17]
      else if (cmd.b1 == OP_RD_LOCK && nul)
         rd = {2'b11, lock};                           // [RULE_18]
      else if (cmd.b1 == OP_RD_LOCK && alt)
         rd = fuse_hi;                                 // [RULE_20]
      else if (cmd.b1 == OP_RD_FUSE && nul)
         rd = fuse_lo;                                 // [RULE_20]
      else if (cmd.b1 == OP_RD_FUSE && alt)
         rd = fuse_ex;                                 // [RULE_20]
      else if (cmd.b1 == OP_RD_SIG)
         rd = (in_byte[1:0] == 2'd0) ? SIG0 :
              (in_byte[1:0] == 2'd1) ? SIG1 :
              (in_byte[1:0] == 2'd2) ? SIG2 : 8'h00;
      else if (cmd.b1 == OP_RD_CAL)
         rd = CAL;
      else if (cmd.b1 == OP_POLL)
         rd = {7'd0, busy};                            // [RULE_21]
   end

   // -------------------------------------------------
   // Wishbone slave
   // -------------------------------------------------
   wire req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Write lands on the edge where the master sees ack, not before
   wire wr_ct  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i
                 & sel_ct & wb_sel_i[0];
   wire sel_ct = wb_adr_i == REG_CTRL;
   wire sel_st = wb_adr_i == REG_STATUS;
   wire sel_cf = wb_adr_i == REG_CONFIG;
   wire [31:0] stat_w = {27'd0, cnt == 5'd0, busy, state};
   wire [31:0] cfg_w  = {fuse_ex, fuse_hi, fuse_lo, 2'b11, lock};
   wire [31:0] rmux   = sel_ct ? {31'd0, blocked} :
                        sel_st ? stat_w :
                        sel_cf ? cfg_w : 32'h0000_0000;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         blocked  <= 1'b0;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i)
            wb_dat_o <= rmux;
         if (wr_ct)
            blocked <= wb_dat_i[CTRL_BLOCK];
      end
   end

   // -------------------------------------------------
   // Checks
   // -------------------------------------------------
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   chk_miso_fall_edge: assert property ( // [RULE_02]
      $changed(miso) |-> $past(sck_fall))
      else $error("MISO moved without a clock fall");

   chk_count_rise_edge: assert property ( // [RULE_01]
      $changed(cnt) && state != ST_IDLE |-> $past(sck_rise))
      else $error("Bit count moved without a clock rise");

   chk_enable_reset_low: assert property ( // [RULE_07]
      $rose(state == ST_ENABLED)
         |-> $past(prog_mode) && $past(pe_ok))
      else $error("Enable taken outside reset or bad code");

   chk_echo_second: assert property ( // [RULE_05]
      byte_end && cnt[4:3] == 2'd1 |=> out_sr == cmd.b2)
      else $error("Second byte not echoed");

   chk_poll_busy: assert property ( // [RULE_21]
      byte_end && cnt[4:3] == 2'd2 && cmd.b1 == OP_POLL
         |=> out_sr[0] == $past(busy))
      else $error("Poll bit does not show busy");

   chk_erase_ff: assert property ( // [RULE_24]
      do_erase |=> flash[0] == ERASED_WORD
                   && ee[0] == ERASED_BYTE && lock == LOCK_RST)
      else $error("Erase left data behind");

   chk_lock_only_clear: assert property ( // [RULE_18]
      !$past(do_erase) |-> (lock & ~$past(lock)) == 6'd0)
      else $error("Lock bit unprogrammed without erase");

   chk_flash_wait: assert property ( // [RULE_11]
      do_pwr |=> wait_cnt == 32'(FLASH_WAIT) ##1 busy)
      else $error("Flash write busy time wrong");

   chk_busy_blocks: assert property ( // [RULE_12]
      busy && frame_end && cmd.b1 == OP_EE_WR |=> $stable(ee[ea_wr]))
      else $error("EEPROM written while busy");

   chk_epage_clear: assert property ( // [RULE_14]
      do_epage |=> emask == 4'h0)
      else $error("EEPROM load marks kept after page write");

endmodule : isp_port

/* dv/isp_programmer.sv */
`timescale 1ns/1ps
// ---------------------------------------------
// Programmer model: serial master on the link
// ---------------------------------------------
module isp_programmer #(
   parameter realtime HALF     = 62.5,
   // Power-up wait cut down so the run stays short
   parameter realtime PWR_WAIT = 2000.0
) (
   output logic      sck,
   output logic      mosi,
   output logic      pin_rst_n,
   input  wire logic miso
);
   initial begin
      sck       = 1'b0;
      mosi      = 1'b0;
      pin_rst_n = 1'b0;
   end

   task automatic xfer(input logic [31:0] cmd, output logic [31:0] resp);
      for (int i = 31; i >= 0; i--) begin
         mosi = cmd[i];
         #(HALF);
         sck     = 1'b1;
         resp[i] = miso;
         #(HALF);
         sck = 1'b0;
      end
      // Idle line flips so a stale bit is never mistaken for data
      mosi = ~mosi;
      #(HALF * 2);
   endtask : xfer

   task automatic enable(output logic [7:0] echo);
      logic [31:0] resp;
      echo = 8'h00;
      #(PWR_WAIT);
      for (int t = 0; t < 3 && echo !== 8'h53; t++) begin
         xfer(32'hAC53_0000, resp);
         echo = resp[15:8];
         if (echo !== 8'h53) begin
            pin_rst_n = 1'b1;
            #(HALF * 4);
            pin_rst_n = 1'b0;
            #(HALF * 4);
         end
      end
   endtask : enable

   task automatic release_reset;
      pin_rst_n = 1'b1;
      #(HALF * 4);
   endtask : release_reset
endmodule : isp_programmer

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
   import isp_pkg::*;
   localparam logic [7:0]  FSUB [3] = '{8'hA0, 8'hA8, 8'hA4};
   localparam logic [15:0] FRD  [3] = '{16'h5000, 16'h5808, 16'h5008};
   localparam logic [7:0]  FVAL [3] = '{8'hE1, 8'hD2, 8'hF5};

   logic        clk_sys, rstn;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i, echo;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, r;
   wire logic   sck, mosi, pin_rst_n, miso;
   int          bad_count, n_tests;

   isp_port #(.FA_W(8), .FLASH_WAIT(600), .FUSE_WAIT(600),
              .EE_WAIT(1200), .ERASE_WAIT(600)) dut (
      .clk_sys(clk_sys), .rstn(rstn), .pin_rst_n(pin_rst_n), .sck(sck),
      .mosi(mosi), .miso(miso), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

   isp_programmer prog (
      .sck(sck), .mosi(mosi), .pin_rst_n(pin_rst_n), .miso(miso));

   // ---------------------------------------------
   // Shared helpers
   // ---------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h, want %h", $time, got, exp);
      end
   endtask : check

   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [31:0] wd, output logic [31:0] rd);
      int n = 0;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= wd;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 16);
      rd = wb_dat_o;
      if (wb_ack_o !== 1'b1) begin
         bad_count++;
         $display("wrong value at %0t: no bus answer", $time);
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb

   task automatic send(input logic [31:0] c);
      prog.xfer(c, r);
   endtask : send

   task automatic rd4(input logic [31:0] c, input logic [7:0] exp);
      prog.xfer(c, r);
      check({24'h0, r[7:0]}, {24'h0, exp});
   endtask : rd4

   // First poll lands inside the write time; later ones repeat until it ends
   task automatic wait_ready;
      int n = 0;
      prog.xfer(32'hF000_0000, r);
      check({31'h0, r[0]}, 32'h1);
      while (r[0] !== 1'b0 && n < 8) begin
         prog.xfer(32'hF000_0000, r);
         n++;
      end
      check({31'h0, r[0]}, 32'h0);
   endtask : wait_ready

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset;
      wb(1'b0, REG_CONFIG, 32'h0, r);
      check(r, 32'hFFFF_FFFF);
      wb(1'b0, REG_STATUS, 32'h0, r);
      check({27'h0, r[4:0]}, 32'h12);
   endtask : t_reset

   task automatic t_enable;
      prog.enable(echo);
      check({24'h0, echo}, 32'h53);
      wb(1'b0, REG_STATUS, 32'h0, r);
      check({29'h0, r[2:0]}, 32'h4);
      for (int i = 0; i < 3; i++)
         rd4({16'h3000, 6'h0, i[1:0], 8'h00}, 8'h01 + 8'(i));
      rd4(32'h3800_0000, 8'h80);
   endtask : t_enable

   task automatic t_flash;
      send(32'h4000_4534);
      send(32'h4800_4512);
      send(32'h4C00_4000);
      wait_ready;
      rd4(32'h2000_4500, 8'h34);
      rd4(32'h2800_4500, 8'h12);
      rd4(32'h2000_0500, 8'hFF);
   endtask : t_flash

   task automatic t_eeprom;
      send(32'hC001_23A5);
      // Second write lands inside the busy time and must be dropped
      send(32'hC001_2311);
      wait_ready;
      rd4(32'hA001_2300, 8'hA5);
      rd4(32'hA000_2300, 8'hFF);
      send(32'hC100_015A);
      send(32'hC201_2000);
      wait_ready;
      rd4(32'hA001_2100, 8'h5A);
      rd4(32'hA001_2300, 8'hA5);
      rd4(32'hA001_2000, 8'hFF);
   endtask : t_eeprom

   task automatic t_config;
      prog.xfer(32'h5800_0000, r);
      check({26'h0, r[5:0]}, 32'h3F);
      send(32'hACE0_00F0);
      wait_ready;
      prog.xfer(32'h5800_0000, r);
      check({26'h0, r[5:0]}, 32'h30);
      for (int i = 0; i < 3; i++) begin
         send({8'hAC, FSUB[i], 8'h00, FVAL[i]});
         wait_ready;
         rd4({FRD[i], 16'h0000}, FVAL[i]);
      end
      wb(1'b0, REG_CONFIG, 32'h0, r);
      check(r, 32'hF5D2_E1F0);
   endtask : t_config

   // Blocked link drops writes; stray bus address reads zero
   task automatic t_block;
      wb(1'b1, REG_CTRL, 32'h1, r);
      send(32'hC000_3077);
      wb(1'b0, REG_STATUS, 32'h0, r);
      check({31'h0, r[3]}, 32'h0);
      wb(1'b1, REG_CTRL, 32'h0, r);
      rd4(32'hA000_3000, 8'hFF);
      wb(1'b1, 8'hFC, 32'hFFFF_FFFF, r);
      wb(1'b0, 8'hFC, 32'h0, r);
      check(r, 32'h0);
      wb(1'b0, REG_CONFIG, 32'h0, r);
      check(r, 32'hF5D2_E1F0);
   endtask : t_block

   task automatic t_erase;
      send(32'hAC80_0000);
      wait_ready;
      rd4(32'h2000_4500, 8'hFF);
      rd4(32'h2800_4500, 8'hFF);
      rd4(32'hA001_2300, 8'hFF);
      rd4(32'hA001_2100, 8'hFF);
   endtask : t_erase

   task automatic t_leave;
      prog.release_reset;
      wb(1'b0, REG_STATUS, 32'h0, r);
      check({29'h0, r[2:0]}, 32'h1);
      send(32'hAC53_0000);
      wb(1'b0, REG_STATUS, 32'h0, r);
      check({29'h0, r[2:0]}, 32'h1);
   endtask : t_leave

   // ---------------------------------------------
   // Run control
   // ---------------------------------------------
   task automatic report_and_stop;
      if (bad_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (90000) @(posedge clk_sys);
      bad_count++;
      report_and_stop;
   end

   initial begin
      rstn     = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i  = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0000_0000;
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (5) @(posedge clk_sys);
      t_reset;
      t_enable;
      t_flash;
      t_eeprom;
      t_config;
      t_block;
      t_erase;
      t_leave;
      report_and_stop;
   end
endmodule : tb
